//--- design/drpf_top.sv
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Permission checker and fault-record logger behind an AHB-Lite slave
module drpf_top
  import drpf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // DMA request (same clock)
  input wire logic dma_valid,
  input wire logic [63:0] dma_pte,
  input wire logic dma_is_read,
  input wire logic dma_zero_len,
  input wire logic [1:0] dma_address_kind,
  input wire logic [15:0] dma_requester_tag,
  input wire logic [51:0] dma_page,
  input wire logic [7:0] dma_fault_cause,
  // Interrupt-remapping fault report (same clock)
  input wire logic irq_fault_valid,
  input wire logic [15:0] irq_requester_tag,
  input wire logic [15:0] irq_index,
  input wire logic [7:0] irq_fault_cause,
  // Verdict and interrupt
  output logic dma_done,
  output logic dma_allow,
  output logic irq_out
);
  // Only whole-word transfers are served; narrower ones read as zero
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // Reset synchroniser
  logic rst_s1_q;
  logic rst_n_q;

  // Permission verdict of the request in this cycle
  logic allow_c;
  logic blocked_c;

  // Bus address phase, held over into the data phase
  logic take_c;
  logic ap_wr_q, ap_wr_d;
  logic ap_rd_d;
  logic [7:0] ap_addr_q, ap_addr_d;

  // Software registers and the one-cycle clear strobe
  logic [31:0] ctrl_q, ctrl_d;
  logic [ST_W-1:0] enable_q, enable_d;
  logic [ST_W-1:0] clr;

  // Fault record, status and fault count
  logic [127:0] rec_q, rec_d;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] status_q, status_d;
  logic [31:0] count_q, count_d;

  // Next values of the registered outputs
  logic [31:0] hrdata_d;
  logic dma_done_d;
  logic dma_allow_d;
  logic irq_out_d;

  // The status word is read back through one bus word
  if (ST_W > 32) begin : g_chk_st_w
    $error("status field wider than a bus word");
  end

  // The page field of the record must match the page port
  if (REC_PG_HI - REC_PG_LO + 1 != 52) begin : g_chk_pg_w
    $error("page field width does not match the page port");
  end

  // The interrupt index field must match the index port
  if (REC_PG_HI - REC_IX_LO + 1 != 16) begin : g_chk_ix_w
    $error("index field width does not match the index port");
  end

  // The capability bit must sit inside the control word
  if (CTRL_ZLR_BIT > 31) begin : g_chk_ctrl
    $error("capability bit outside the control word");
  end

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Only entry bits 1:0 reach the checker's decision
  drpf_perm_check u_check (
    .pte(dma_pte),
    .is_read(dma_is_read),
    .zero_len(dma_zero_len),
    .zlr_cap(ctrl_q[CTRL_ZLR_BIT]),
    .allow(allow_c)
  );

  // A request that the entry refuses is blocked and logged
  assign blocked_c = dma_valid && !allow_c;

  // Address phase capture; the slave never stalls, so every whole-word one is taken
  always_comb begin
    take_c = hsel && htrans[1] && (hsize == SIZE_WORD);
    ap_wr_d = take_c && hwrite;
    ap_rd_d = take_c && !hwrite;
    ap_addr_d = ap_addr_q;
    if (take_c) begin
      ap_addr_d = haddr;
    end
  end

  // Address phase registers
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q <= ap_wr_d;
      ap_addr_q <= ap_addr_d;
    end
  end

  // Register writes land in the data phase, when hwdata stands
  always_comb begin
    ctrl_d = ctrl_q;
    enable_d = enable_q;
    clr = '0;
    if (ap_wr_q) begin
      unique case (ap_addr_q)
        OFS_CTRL: ctrl_d = {31'h0, hwdata[CTRL_ZLR_BIT]};
        OFS_CLEAR: clr = hwdata[ST_W-1:0];
        OFS_ENABLE: enable_d = hwdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Control word; the capability bit changes how reads are judged
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Interrupt enables hold their value until software writes them
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      enable_q <= '0;
    end else begin
      enable_q <= enable_d;
    end
  end

  // Read data is chosen in the address phase and registered, so it
  // stands through the whole data phase that follows
  always_comb begin
    hrdata_d = 32'h0000_0000;
    if (ap_rd_d) begin
      unique case (haddr)
        OFS_CTRL: hrdata_d = ctrl_q;
        OFS_STATUS: hrdata_d = {{(32-ST_W){1'b0}}, status_q};
        OFS_ENABLE: hrdata_d = {{(32-ST_W){1'b0}}, enable_q};
        OFS_REC0: hrdata_d = rec_q[31:0];
        OFS_REC1: hrdata_d = rec_q[63:32];
        OFS_REC2: hrdata_d = rec_q[95:64];
        OFS_REC3: hrdata_d = rec_q[127:96];
        OFS_COUNT: hrdata_d = count_q;
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= hrdata_d;
    end
  end

  // Fault record; a new fault overwrites the last one, so software
  // must read it out before the next fault to see every record
  always_comb begin
    rec_d = rec_q;
    if (blocked_c) begin
      rec_d = '0; // Reserved ranges stay zero
      rec_d[REC_KIND_BIT] = dma_is_read ? KIND_READ : KIND_WRITE;
      rec_d[REC_AT_HI:REC_AT_LO] = dma_address_kind;
      rec_d[REC_FC_HI:REC_FC_LO] = dma_fault_cause;
      rec_d[REC_RT_HI:REC_RT_LO] = dma_requester_tag;
      rec_d[REC_PG_HI:REC_PG_LO] = dma_page;
    end else if (irq_fault_valid) begin
      // Kind, address kind and bits 47:12 stay zero
      rec_d = '0;
      rec_d[REC_FC_HI:REC_FC_LO] = irq_fault_cause;
      rec_d[REC_RT_HI:REC_RT_LO] = irq_requester_tag;
      rec_d[REC_PG_HI:REC_IX_LO] = irq_index;
    end
  end

  // Fault record register
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rec_q <= '0;
    end else begin
      rec_q <= rec_d;
    end
  end

  // Events: a DMA fault wins; an interrupt fault in the same cycle is
  // dropped, since there is one record, and only marked as an overrun
  always_comb begin
    ev = '0;
    ev[ST_DMA_FAULT] = blocked_c;
    ev[ST_IRQ_FAULT] = irq_fault_valid && !blocked_c;
    ev[ST_OVERRUN] = irq_fault_valid && blocked_c;
    // Set wins over a clear written in the same cycle
    status_d = (status_q & ~clr) | ev;
    count_d = count_q;
    if (ev[ST_DMA_FAULT] || ev[ST_IRQ_FAULT]) begin
      count_d = count_q + 32'h0000_0001; // Wraps after 2^32 faults
    end
  end

  // Sticky status bits
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // Count of logged faults, dropped ones not included
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q <= 32'h0000_0000;
    end else begin
      count_q <= count_d;
    end
  end

  // Verdict follows its request by exactly one cycle
  always_comb begin
    dma_done_d = dma_valid;
    dma_allow_d = dma_valid && allow_c;
  end

  // Verdict registers
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dma_done <= 1'b0;
      dma_allow <= 1'b0;
    end else begin
      dma_done <= dma_done_d;
      dma_allow <= dma_allow_d;
    end
  end

  // Level interrupt from the next status, so it rises with the bit
  // instead of one cycle behind it
  always_comb begin
    irq_out_d = |(status_d & enable_d);
  end

  // Interrupt register
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_out_d;
    end
  end

  // Zero wait states, OKAY only
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- design/drpf_pkg.sv
// Operation
// - The spare software-owned bits 6:2 of a page-table entry never affect translation or permission checking.
// - A DMA write through an entry whose store-permit bit is 0 is blocked, and allowed when that bit is 1.
// - A DMA read through an entry whose fetch-permit bit is 0 is blocked, and allowed when that bit is 1.
// - With the zero-length-read capability set, zero-length reads to write-only pages skip the read check.
// - Record bit 126 holds the access kind of a DMA fault: 0 for write, 1 for read or atomic.
// - Record bits 125:124 hold the address kind of the faulting DMA request.
// - Record bits 79:64 hold the requester tag of the faulting request.
// - Record bits 103:96 hold the fault cause, and bits 63:12 the page address for DMA faults.
// - For interrupt faults, bits 63:48 hold the table index and bits 47:12 are zero.
package drpf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLEAR = 8'h08;
  localparam logic [7:0] OFS_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_REC0 = 8'h10;
  localparam logic [7:0] OFS_REC1 = 8'h14;
  localparam logic [7:0] OFS_REC2 = 8'h18;
  localparam logic [7:0] OFS_REC3 = 8'h1c;
  localparam logic [7:0] OFS_COUNT = 8'h20;
  // Control bits
  localparam int CTRL_ZLR_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status and interrupt bits
  localparam int ST_DMA_FAULT = 0;
  localparam int ST_IRQ_FAULT = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_W = 3;
  // Page-table entry permission bits
  localparam int PTE_READ_BIT = 0;
  localparam int PTE_WRITE_BIT = 1;
  // Fault record fields
  localparam int REC_KIND_BIT = 126;
  localparam int REC_AT_HI = 125;
  localparam int REC_AT_LO = 124;
  localparam int REC_FC_HI = 103;
  localparam int REC_FC_LO = 96;
  localparam int REC_RT_HI = 79;
  localparam int REC_RT_LO = 64;
  localparam int REC_PG_HI = 63;
  localparam int REC_PG_LO = 12;
  localparam int REC_IX_LO = 48;
  // Access kind values
  localparam logic KIND_WRITE = 1'b0;
  localparam logic KIND_READ = 1'b1;
endpackage

//--- design/drpf_perm_check.sv
`timescale 1ns/1ps
`default_nettype none
// Combinational permission check of one request against an entry
module drpf_perm_check
  import drpf_pkg::*;
(
  // Request
  input wire logic [63:0] pte,
  input wire logic is_read,
  input wire logic zero_len,
  input wire logic zlr_cap,
  // Verdict
  output logic allow
);
  logic rd_ok;
  logic wr_ok;
  // Only bits 1:0 are looked at; spare bits 6:2 arrive on pte but are never used
  always_comb begin
    wr_ok = pte[PTE_WRITE_BIT];
    rd_ok = pte[PTE_READ_BIT];
    // Zero-length read to a write-only page is exempt
    if (zlr_cap && zero_len && pte[PTE_WRITE_BIT]) begin
      rd_ok = 1'b1;
    end
    allow = is_read ? rd_ok : wr_ok;
  end
endmodule
`default_nettype wire

//--- verification/drpf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of verdict timing, permissions and bus answers
module drpf_assertions (
  // Watched ports
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic dma_valid,
  input wire logic [63:0] dma_pte,
  input wire logic dma_is_read,
  input wire logic dma_zero_len,
  input wire logic dma_done,
  input wire logic dma_allow
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Verdict lands exactly one cycle after its request
  chk_done_late: assert property (dma_valid |=> dma_done)
    else $error("verdict missing");
  chk_done_cause: assert property (dma_done |-> $past(dma_valid))
    else $error("stray verdict");
  // Spare entry bits vary freely, so only bits 1:0 may matter
  chk_write_perm: assert property (
    dma_valid && !dma_is_read |=> dma_allow == $past(dma_pte[1]))
    else $error("write verdict wrong");
  chk_read_perm: assert property (
    dma_valid && dma_is_read && !dma_zero_len
    |=> dma_allow == $past(dma_pte[0]))
    else $error("read verdict wrong");
  chk_no_perm: assert property (
    dma_valid && dma_pte[1:0] == 2'h0 |=> !dma_allow)
    else $error("unmapped page allowed");
  // Unmapped reads give zero; bus side never stalls and never errors
  chk_unmapped_zero: assert property (
    hsel && htrans[1] && !hwrite && haddr == 8'hfc |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_hresp_okay: assert property (!hresp)
    else $error("error response");
  chk_ready_high: assert property (hreadyout)
    else $error("wait state");
endmodule
bind drpf_top drpf_assertions chk_u (.*);
`default_nettype wire

//--- verification/drpf_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// I/O side: issues one-cycle DMA and interrupt-fault requests
module drpf_dev_model (
  // Clock
  input wire logic clk,
  // DMA request
  output logic dma_valid,
  output logic [63:0] dma_pte,
  output logic dma_is_read,
  output logic dma_zero_len,
  output logic [1:0] dma_address_kind,
  output logic [15:0] dma_requester_tag,
  output logic [51:0] dma_page,
  output logic [7:0] dma_fault_cause,
  // Interrupt-remapping fault
  output logic irq_fault_valid,
  output logic [15:0] irq_requester_tag,
  output logic [15:0] irq_index,
  output logic [7:0] irq_fault_cause
);
  logic [143:0] dv = '0;
  logic [39:0] iv = '0;
  initial dma_valid = 1'b0;
  initial irq_fault_valid = 1'b0;
  assign {dma_pte, dma_is_read, dma_zero_len, dma_address_kind,
    dma_requester_tag, dma_page, dma_fault_cause} = dv;
  assign {irq_requester_tag, irq_index, irq_fault_cause} = iv;
  // Fresh entry each request, no stale copy kept
  task req(input logic [63:0] p, input logic r, z, input logic [1:0] a,
    input logic [15:0] t, input logic [51:0] g, input logic [7:0] c);
    @(posedge clk);
    dma_valid <= 1'b1;
    dv <= {p, r, z, a, t, g, c};
    @(posedge clk);
    dma_valid <= 1'b0;
    dv <= ~dv; // Released fields show junk, not the old value
  endtask
  // Interrupt fault report, one-cycle pulse
  task irqf(input logic [15:0] t, x, input logic [7:0] c);
    @(posedge clk);
    irq_fault_valid <= 1'b1;
    iv <= {t, x, c};
    @(posedge clk);
    irq_fault_valid <= 1'b0;
    iv <= ~iv;
  endtask
endmodule
`default_nettype wire

//--- verification/test_dma_remap_permission_fault_log.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: permission verdicts, fault records and interrupt
module test_dma_remap_permission_fault_log
  import drpf_pkg::*;
;
  logic core_clk, resetn, hsel, hwrite, hreadyout, hresp, irq_out;
  logic [7:0] haddr, dma_fault_cause, irq_fault_cause;
  logic [1:0] htrans, dma_address_kind;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [63:0] dma_pte;
  logic [51:0] dma_page;
  logic [15:0] dma_requester_tag, irq_requester_tag, irq_index;
  logic dma_valid, dma_is_read, dma_zero_len, irq_fault_valid;
  logic dma_done, dma_allow;
  logic [127:0] r;
  int num_errors = 0;
  int checks = 0;
  drpf_top dut_u (.*);
  drpf_dev_model dev_u (.clk(core_clk), .*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task cmp(input logic [127:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single AHB transfer; waits on hready in both phases
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {hwrite, haddr, htrans} <= {w, a, 2'h2};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task rec();
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, OFS_REC0 + 8'(4 * i), 32'h0);
      r[32*i+:32] = q;
    end
  endtask
  task dma(input logic [63:0] p, input logic rd, z, e);
    dev_u.req(p, rd, z, 2'h1, 16'h0, 52'h0, 8'h0);
    for (int n = 0; n < 4 && dma_done !== 1'b1; n++) @(posedge core_clk);
    cmp({dma_done, dma_allow}, {1'b1, e});
  endtask
  // Requests two idle cycles apart, spare bits scrambled each time
  task t_perm();
    for (int i = 0; i < 8; i++)
      dma({57'h1, 5'(i * 7), 2'(i)}, i[2], 1'b0, i[2] ? i[0] : i[1]);
  endtask
  task t_zlr();
    dma(64'h2, 1'b1, 1'b1, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h1);
    dma(64'h2, 1'b1, 1'b1, 1'b1);
  endtask
  // Blocked read builds a record and raises, masks, clears the interrupt
  task t_rec();
    bus(1'b1, OFS_CLEAR, 32'h7);
    bus(1'b1, OFS_ENABLE, 32'h1);
    dev_u.req(64'h0, 1'b1, 1'b0, 2'h2, 16'hbeef, 52'h123456789abcd, 8'h5a);
    repeat (2) @(posedge core_clk);
    cmp(irq_out, 1'b1);
    rec();
    cmp(r, {2'h1, 2'h2, 20'h0, 8'h5a, 16'h0, 16'hbeef, 52'h123456789abcd, 12'h0});
    bus(1'b1, OFS_ENABLE, 32'h0);
    repeat (2) @(posedge core_clk);
    cmp(irq_out, 1'b0);
    bus(1'b1, OFS_ENABLE, 32'h1);
    repeat (2) @(posedge core_clk);
    cmp(irq_out, 1'b1);
    bus(1'b1, OFS_CLEAR, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    cmp({q[ST_DMA_FAULT], irq_out}, 2'h0);
  endtask
  task t_irq();
    dev_u.irqf(16'h1234, 16'habcd, 8'h26);
    rec();
    cmp(r, {24'h0, 8'h26, 16'h0, 16'h1234, 16'habcd, 48'h0});
    bus(1'b0, 8'hfc, 32'h0);
    cmp(q, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0);
    cmp(q, 32'h7);
  endtask
  task test_done();
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    {resetn, hwrite, htrans, haddr, hwdata} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_perm();
    t_zlr();
    t_rec();
    t_irq();
    test_done();
  end
  // Whole run needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
